/* File: hdl/atie_emulator.sv */
// Absolute-to-incremental emulator: start-up sequencer and tracking
//
// Operation
// [R1] Power-up standby: A, B, Z, ready low
// [R2] Start needs request held 50 ms
// [R3] Request tied active starts automatically
// [R4] Start-up train count equals absolute position
// [R5] One Z pulse precedes start-up train
// [R6] Ready rises when train complete
// [R7] After start-up, tracking drives A, B, Z
// [R8] Z decoded from position; A/B quadrature
// [R9] Direction select picks counting rotation sense
// [R10] Ready low means controller must restart
// [R11] Fault forces ready low
// [R12] Recheck position, send extra pulses until matched
// [R13] Shaft too fast: ready stays low
// [R14] 1024 pulses per turn, x4 edges
// [R15] Synchronise request, count hold cycles
// [R16] Train phase order counts up; pursuit passes may count down
`timescale 1ns/100ps
module atie_emulator import atie_pkg::*; #(
  parameter int PW       = POS_W,
  parameter int HOLD_CYC = RESTART_HOLD_CYC
) (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          restart_req,
  input  wire logic          dir_cw_up,
  input  wire logic [PW-1:0] abs_pos,
  input  wire logic          fault,
  output logic               chan_a,
  output logic               chan_b,
  output logic               chan_z,
  output logic               ready
);
  localparam int ZW = $clog2(Z_PULSE_CYC + 1);
  localparam int RW = $clog2(MAX_RETRY + 1);
  localparam logic [ZW-1:0] Z_LAST    = ZW'(Z_PULSE_CYC - 1);
  localparam logic [RW-1:0] RETRY_MAX = RW'(MAX_RETRY);
  localparam logic [PW-1:0] LAG_MAX   = PW'(MAX_LAG);
  localparam logic [PW-1:0] Z_CODE    = PW'(Z_POS);

  atie_state_e   state_q;
  atie_state_e   state_d;
  logic [PW-1:0] pos_eff;
  logic [PW-1:0] goal;
  logic [PW-1:0] diff;
  logic [PW-1:0] lag;
  logic [PW-1:0] sent_q;
  logic [PW-1:0] target_q;
  logic [ZW-1:0] zcnt_q;
  logic [RW-1:0] retry_q;
  logic          req_ok;
  logic          step_ready;
  logic          step_valid;
  logic          step_up;
  logic          step_fire;
  logic          match;
  logic          pos_same;
  logic          lag_over;
  logic          z_d;
  logic          first_pass;
  logic          standby;

  // 50 ms qualified request; a tied-high request qualifies after reset
  atie_req_filter #(
    .HOLD_CYC (HOLD_CYC)
  ) u_req (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .req_raw  (restart_req),
    .req_ok   (req_ok)
  );

  // Counting sense: reflect the code so chosen rotation counts up
  assign pos_eff = dir_cw_up ? abs_pos : ({PW{1'b0}} - abs_pos);  // [R9]

  // Start-up chases a latched target, tracking chases live position
  assign goal       = (state_q == ST_RUN) ? pos_eff : target_q;   // [R7]
  assign diff       = goal - sent_q;
  assign match      = (diff == '0);
  // First pass only counts up, so pulses sent equal the position;
  // pursuit passes take the short way to a shaft that moved
  assign first_pass = (state_q == ST_TRAIN) && (retry_q == '0);
  assign step_up    = first_pass || ~diff[PW-1];                  // [R16]
  assign step_valid = ((state_q == ST_TRAIN) || (state_q == ST_RUN))
                      && !match;                                  // [R4]
  assign step_fire  = step_valid && step_ready;
  assign pos_same   = (pos_eff == sent_q);
  assign standby    = (state_q == ST_STANDBY);
  assign lag        = step_up ? diff : ({PW{1'b0}} - diff);
  // Lag beyond the limit means the output lost the shaft
  assign lag_over   = (state_q == ST_RUN) && (lag > LAG_MAX);     // [R11]

  // Sequencer next state; fault wins from every state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_STANDBY: begin
        if (req_ok) begin
          state_d = ST_ZPULSE;                                    // [R2] [R3]
        end
      end
      ST_ZPULSE: begin
        if (zcnt_q == Z_LAST) begin
          state_d = ST_TRAIN;                                     // [R5]
        end
      end
      ST_TRAIN: begin
        if (match) begin
          state_d = ST_CHECK;                                     // [R12]
        end
      end
      ST_CHECK: begin
        if (pos_same) begin
          state_d = ST_RUN;                                       // [R6]
        end else if (retry_q == RETRY_MAX) begin
          state_d = ST_STANDBY;                                   // [R13]
        end else begin
          state_d = ST_TRAIN;                                     // [R12]
        end
      end
      ST_RUN: begin
        if (lag_over) begin
          state_d = ST_STANDBY;                                   // [R11]
        end
      end
      default: begin
        state_d = ST_STANDBY;
      end
    endcase
    if (fault) begin
      state_d = ST_STANDBY;                                       // [R11]
    end
  end

  // Z: start marker pulse, then decoded from the absolute code
  assign z_d = (state_d == ST_ZPULSE) ||                          // [R5]
               ((state_d == ST_RUN) && (abs_pos == Z_CODE));      // [R8]

  // State, Z output and ready flag registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_STANDBY;                                      // [R1]
      chan_z  <= 1'b0;
      ready   <= 1'b0;
    end else begin
      state_q <= state_d;
      chan_z  <= z_d;
      ready   <= (state_d == ST_RUN);                             // [R6] [R10]
    end
  end

  // Sent count mirrors what the external x4 counter holds
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sent_q   <= '0;
      target_q <= '0;
      zcnt_q   <= '0;
      retry_q  <= '0;
    end else if (state_q == ST_STANDBY) begin
      sent_q   <= '0;
      target_q <= pos_eff;                                        // [R4]
      zcnt_q   <= '0;
      retry_q  <= '0;
    end else begin
      if (step_fire) begin
        sent_q <= step_up ? sent_q + 1'b1 : sent_q - 1'b1;        // [R14]
      end
      if (state_q == ST_ZPULSE) begin
        zcnt_q <= zcnt_q + 1'b1;
      end
      if ((state_q == ST_CHECK) && !pos_same) begin
        target_q <= pos_eff;                                      // [R12]
        retry_q  <= retry_q + 1'b1;
      end
    end
  end

  // Channels stay cleared in standby, so shaft motion does nothing
  atie_quad_gen #(
    .GAP_CYC    (STEP_GAP_CYC)
  ) u_quad (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .clear      (standby),                                        // [R1]
    .step_valid (step_valid),
    .step_up    (step_up),
    .step_ready (step_ready),
    .chan_a     (chan_a),
    .chan_b     (chan_b)
  );

  property p_standby_quiet;
    @(posedge core_clk) disable iff (!rst_n)
      (state_q == ST_STANDBY) && $past(state_q == ST_STANDBY)
      |-> !chan_a && !chan_b && !chan_z && !ready;
  endproperty
  a_standby_quiet: assert property (p_standby_quiet)              // [R1]
    else $error("outputs active in standby");

  property p_z_first;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(state_q == ST_TRAIN) |-> $past(state_q) != ST_STANDBY;
  endproperty
  a_z_first: assert property (p_z_first)                          // [R5]
    else $error("train started without Z pulse");

  property p_ready_matched;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(ready) |-> $past(sent_q) == $past(pos_eff);
  endproperty
  a_ready_matched: assert property (p_ready_matched)              // [R6]
    else $error("ready raised with count mismatch");

  property p_fault_drop;
    @(posedge core_clk) disable iff (!rst_n)
      fault |=> !ready && (state_q == ST_STANDBY);
  endproperty
  a_fault_drop: assert property (p_fault_drop)                    // [R11]
    else $error("fault did not drop ready");

  property p_retry_give_up;
    @(posedge core_clk) disable iff (!rst_n)
      (state_q == ST_CHECK) && !pos_same && (retry_q == RETRY_MAX)
      |=> !ready && (state_q == ST_STANDBY);
  endproperty
  a_retry_give_up: assert property (p_retry_give_up)              // [R13]
    else $error("ready not withheld after pursuit failed");

  property p_step_counts;
    @(posedge core_clk) disable iff (!rst_n)
      step_fire && step_up && (state_q == ST_TRAIN) && !fault
      |=> sent_q == $past(sent_q) + 1'b1;
  endproperty
  a_step_counts: assert property (p_step_counts)                  // [R4]
    else $error("start-up step not counted");

  property p_z_decode;
    @(posedge core_clk) disable iff (!rst_n)
      (state_q == ST_RUN) && (abs_pos == Z_CODE) && !fault && !lag_over
      |=> chan_z;
  endproperty
  a_z_decode: assert property (p_z_decode)                        // [R8]
    else $error("Z not decoded from position");

  property p_start_held;
    @(posedge core_clk) disable iff (!rst_n)
      (state_q == ST_STANDBY) && !req_ok |=> (state_q == ST_STANDBY);
  endproperty
  a_start_held: assert property (p_start_held)                    // [R2]
    else $error("start-up began without qualified request");

  property p_z_high;
    @(posedge core_clk) disable iff (!rst_n)
      (state_q == ST_ZPULSE) |-> chan_z;
  endproperty
  a_z_high: assert property (p_z_high)                            // [R5]
    else $error("Z low during start marker");

  property p_ab_still;
    @(posedge core_clk) disable iff (!rst_n)
      (state_q == ST_ZPULSE) && $past(state_q == ST_ZPULSE)
      |-> $stable(chan_a) && $stable(chan_b);
  endproperty
  a_ab_still: assert property (p_ab_still)                        // [R5]
    else $error("quadrature moved during Z marker");

  property p_train_up;
    @(posedge core_clk) disable iff (!rst_n)
      first_pass && !fault |=> sent_q >= $past(sent_q);
  endproperty
  a_train_up: assert property (p_train_up)                        // [R16]
    else $error("first start-up pass counted down");

  property p_lag_drop;
    @(posedge core_clk) disable iff (!rst_n)
      lag_over |=> !ready && (state_q == ST_STANDBY);
  endproperty
  a_lag_drop: assert property (p_lag_drop)                        // [R11]
    else $error("lost shaft did not drop ready");

  property p_ready_run;
    @(posedge core_clk) disable iff (!rst_n)
      ready |-> (state_q == ST_RUN);
  endproperty
  a_ready_run: assert property (p_ready_run)                      // [R6]
    else $error("ready high outside normal operation");

  property p_run_tracks;
    @(posedge core_clk) disable iff (!rst_n)
      (state_q == ST_RUN) && !match && step_ready && !fault && !lag_over
      |=> sent_q != $past(sent_q);
  endproperty
  a_run_tracks: assert property (p_run_tracks)                    // [R7]
    else $error("tracking did not follow the shaft");

  property p_check_retry;
    @(posedge core_clk) disable iff (!rst_n)
      (state_q == ST_CHECK) && !pos_same && (retry_q != RETRY_MAX)
      && !fault |=> (state_q == ST_TRAIN) && (target_q == $past(pos_eff));
  endproperty
  a_check_retry: assert property (p_check_retry)                  // [R12]
    else $error("pursuit did not retarget the new position");
endmodule : atie_emulator

/* File: hdl/atie_pkg.sv */
// Shared constants and state type for the incremental emulator
package atie_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS    = 100;
  localparam int RESTART_HOLD_MS  = 50;
  localparam int RESTART_HOLD_CYC =
    (RESTART_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int Z_PULSE_NS       = 1000;
  localparam int Z_PULSE_CYC      =
    (Z_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_GAP_NS      = 500;
  localparam int STEP_GAP_CYC     =
    (STEP_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Resolution: pulses per turn times quadrature edges per pulse
  localparam int MAX_PPR   = 1024;
  localparam int QUAD_MULT = 4;
  localparam int POS_W     = $clog2(MAX_PPR * QUAD_MULT);

  // Start-up pursuit and tracking limits
  localparam int MAX_RETRY = 8;
  localparam int MAX_LAG   = 64;
  localparam int Z_POS     = 0;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_ZPULSE  = 3'b001,
    ST_TRAIN   = 3'b010,
    ST_CHECK   = 3'b011,
    ST_RUN     = 3'b100
  } atie_state_e;
endpackage : atie_pkg

/* File: hdl/atie_quad_gen.sv */
// Quadrature step generator with minimum edge spacing
`timescale 1ns/100ps
module atie_quad_gen import atie_pkg::*; #(
  parameter int GAP_CYC = STEP_GAP_CYC
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic clear,
  input  wire logic step_valid,
  input  wire logic step_up,
  output logic      step_ready,
  output logic      chan_a,
  output logic      chan_b
);
  localparam int GW = $clog2(GAP_CYC + 1);
  localparam logic [GW-1:0] GAP_LAST = GW'(GAP_CYC - 1);

  logic [1:0]    phase_q;
  logic [1:0]    phase_d;
  logic [GW-1:0] gap_q;
  logic          step_fire;

  // Spacing keeps each edge visible to a slow external counter
  assign step_ready = (gap_q == '0) && !clear;
  assign step_fire  = step_valid && step_ready;
  assign phase_d    = clear ? 2'h0 :
                      step_fire ? (step_up ? phase_q + 2'h1
                                           : phase_q - 2'h1) : phase_q;

  // Phase counter mapped to gray code, so one channel moves per step
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 2'h0;
      chan_a  <= 1'b0;
      chan_b  <= 1'b0;
      gap_q   <= '0;
    end else begin
      phase_q <= phase_d;
      chan_a  <= phase_d[1];                               // [R8]
      chan_b  <= phase_d[1] ^ phase_d[0];                  // [R8]
      gap_q   <= step_fire ? GAP_LAST : (gap_q != '0) ? gap_q - 1'b1 : gap_q;
    end
  end

  property p_one_edge;
    @(posedge core_clk) disable iff (!rst_n)
      !clear && !$past(clear) |-> !($changed(chan_a) && $changed(chan_b));
  endproperty
  a_one_edge: assert property (p_one_edge)                 // [R8]
    else $error("both quadrature channels moved together");
endmodule : atie_quad_gen

/* File: hdl/atie_req_filter.sv */
// Start-up request synchroniser and minimum hold qualifier
`timescale 1ns/100ps
module atie_req_filter import atie_pkg::*; #(
  parameter int HOLD_CYC = RESTART_HOLD_CYC
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic req_raw,
  output logic      req_ok
);
  localparam int CW = $clog2(HOLD_CYC + 1);
  localparam logic [CW-1:0] HOLD = CW'(HOLD_CYC);

  logic          sync1_q;
  logic          sync2_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // Saturating count of cycles the request has stayed active
  assign cnt_d  = !sync2_q ? '0 : (cnt_q == HOLD) ? cnt_q : cnt_q + 1'b1;
  assign req_ok = (cnt_q == HOLD);                         // [R2] [R15]

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      cnt_q   <= '0;
    end else begin
      sync1_q <= req_raw;
      sync2_q <= sync1_q;
      cnt_q   <= cnt_d;                                    // [R15]
    end
  end

  property p_hold_reached;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(req_ok) |-> $past(cnt_q) == HOLD - 1'b1;
  endproperty
  a_hold_reached: assert property (p_hold_reached)         // [R2]
    else $error("request qualified before full hold time");

  property p_drop_clears;
    @(posedge core_clk) disable iff (!rst_n)
      !sync2_q |=> !req_ok;
  endproperty
  a_drop_clears: assert property (p_drop_clears)           // [R15]
    else $error("short request not ignored");
endmodule : atie_req_filter

/* File: tb/absolute_to_incremental_emulator_tb.sv */
// Self-checking bench for the absolute-to-incremental emulator
`timescale 1ns/100ps
module absolute_to_incremental_emulator_tb import atie_pkg::*;;
  // Short hold keeps the run brief; expectations use it too
  localparam int HOLD = 20;
  logic             core_clk    = 1'h0;
  logic             rst_n       = 1'h0;
  logic             restart_req = 1'h1;
  logic             dir_cw_up   = 1'h1;
  logic [POS_W-1:0] abs_pos     = 12'h005;
  logic             fault       = 1'h0;
  logic             chan_a;
  logic             chan_b;
  logic             chan_z;
  logic             ready;
  logic [POS_W-1:0] count;
  int               error_cnt   = 0;
  int               tests_run   = 0;

  // 100 ns clock
  always #50 core_clk = ~core_clk;

  atie_emulator #(.HOLD_CYC(HOLD)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .restart_req(restart_req),
    .dir_cw_up(dir_cw_up), .abs_pos(abs_pos), .fault(fault),
    .chan_a(chan_a), .chan_b(chan_b), .chan_z(chan_z), .ready(ready));

  atie_counter_model u_cnt (
    .core_clk(core_clk), .rst_n(rst_n), .chan_a(chan_a),
    .chan_b(chan_b), .chan_z(chan_z), .count(count));

  task automatic chk(input logic [POS_W-1:0] got,
                     input logic [POS_W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  // Bounded wait for ready
  task automatic wait_rdy(input int lim);
    int n;
    n = 0;
    while (ready !== 1'h1 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : wait_rdy

  // One-cycle malfunction pulse with new position and direction
  task automatic flt(input logic dir, input logic [POS_W-1:0] p);
    @(posedge core_clk);
    dir_cw_up <= dir;
    abs_pos   <= p;
    fault     <= 1'h1;
    @(posedge core_clk);
    fault     <= 1'h0;
  endtask : flt

  // Request tied high from power-up: Z first, then train, then ready
  task automatic t_auto();
    int  n;
    logic ab;
    n  = 0;
    ab = 1'h0;
    cyc(1);
    chk({chan_a, chan_b, chan_z, ready}, 12'h000);
    while (chan_z !== 1'h1 && n < 200) begin
      ab |= chan_a | chan_b;
      cyc(1);
      n++;
    end
    chk(ab, 1'h0);
    chk(n >= HOLD, 1'h1);
    wait_rdy(1000);
    chk(ready, 1'h1);
    chk(count, 12'h005);
  endtask : t_auto

  // Tracking down to zero, Z decoded at position 0
  task automatic t_track();
    for (int i = 4; i >= 0; i--) begin
      @(posedge core_clk);
      abs_pos <= i[POS_W-1:0];
      cyc(12);
      chk(count, i[POS_W-1:0]);
    end
    chk(chan_z, 1'h1);
  endtask : t_track

  // Fault drops ready; standby ignores motion and short requests
  task automatic t_stby();
    @(posedge core_clk);
    restart_req <= 1'h0;
    // Dropped request takes two cycles to leave the synchroniser
    repeat (4) @(posedge core_clk);
    flt(1'h1, 12'h000);
    cyc(2);
    chk({chan_a, chan_b, chan_z, ready}, 12'h000);
    @(posedge core_clk);
    abs_pos <= 12'h009;
    cyc(20);
    chk({chan_a, chan_b, chan_z}, 12'h000);
    @(posedge core_clk);
    restart_req <= 1'h1;
    repeat (HOLD - 4) @(posedge core_clk);
    restart_req <= 1'h0;
    cyc(40);
    chk({chan_z, ready}, 12'h000);
  endtask : t_stby

  // Direction low: reflected code counts up anticlockwise
  task automatic t_dir0();
    @(posedge core_clk);
    dir_cw_up   <= 1'h0;
    abs_pos     <= 12'hFFA;
    restart_req <= 1'h1;
    wait_rdy(3000);
    chk(ready, 1'h1);
    chk(count, 12'h006);
    @(posedge core_clk);
    abs_pos <= 12'hFFB;
    cyc(15);
    chk(count, 12'h005);
  endtask : t_dir0

  // Shaft moves mid-train: extra pulses close the gap
  task automatic t_pursuit();
    int n;
    n = 0;
    flt(1'h1, 12'h028);
    while (chan_z !== 1'h1 && n < 200) begin
      cyc(1);
      n++;
    end
    cyc(60);
    @(posedge core_clk);
    abs_pos <= 12'h02D;
    wait_rdy(3000);
    chk(ready, 1'h1);
    chk(count, 12'h02D);
  endtask : t_pursuit

  // Shaft outruns the step rate: pursuit gives up, ready stays low
  task automatic t_fast();
    logic seen;
    seen = 1'h0;
    flt(1'h1, 12'h004);
    cyc(2);
    repeat (1000) begin
      @(posedge core_clk);
      abs_pos <= abs_pos + 12'h001;
      cyc(4);
      seen |= (ready === 1'h1);
    end
    chk(seen, 1'h0);
    wait_rdy(30000);
    chk(ready, 1'h1);
    chk(count, 12'h3EC);
  endtask : t_fast

  // Tracking lag past the limit counts as a malfunction
  task automatic t_lag();
    @(posedge core_clk);
    abs_pos <= 12'h4EC;
    cyc(2);
    chk(ready, 1'h0);
    wait_rdy(8000);
    chk(ready, 1'h1);
    chk(count, 12'h4EC);
  endtask : t_lag

  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'h1;
    t_auto();
    t_track();
    t_stby();
    t_dir0();
    t_pursuit();
    t_fast();
    t_lag();
    end_of_test();
  end

  // Watchdog sized well past the expected run
  initial begin
    #(90000 * 100);
    error_cnt++;
    end_of_test();
  end
endmodule : absolute_to_incremental_emulator_tb

/* File: tb/atie_counter_model.sv */
// External x4 incremental counter model on the emulator's outputs
`timescale 1ns/100ps
module atie_counter_model import atie_pkg::*; (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             chan_a,
  input  wire logic             chan_b,
  input  wire logic             chan_z,
  output logic      [POS_W-1:0] count
);
  logic [1:0] ph_q;
  logic [1:0] ph_d;
  logic [1:0] dlt;

  // Gray phase to ordinal, so 00,01,11,10 is one step up each
  assign ph_d = {chan_a, chan_a ^ chan_b};
  assign dlt  = ph_d - ph_q;

  // Z clears; each single A or B edge is one count, sign from phase order; a double edge is ignored
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_q  <= 2'h0;
      count <= '0;
    end else begin
      ph_q <= ph_d;
      if (chan_z)
        count <= '0;
      else if (dlt == 2'h1)
        count <= count + 12'h001;
      else if (dlt == 2'h3)
        count <= count - 12'h001;
    end
  end
endmodule : atie_counter_model
